// ===== hdl/adc_seq_map.vh
// Register map, field positions, reset values and timing constants of the converter control
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH
// ==================================================
// Register byte addresses (printed offsets are indices, address is index times four)
`define CTRL_INDEX 8'h1F
`define PCFG_INDEX 8'h9F
`define CTRL_ADDR 12'h07C
`define PCFG_ADDR 12'h27C
`define RESULT_ADDR 12'h300
`define STATUS_ADDR 12'h304
`define MASK_ADDR 12'h308
`define PORT_ADDR 12'h30C
// ==================================================
// Control register fields
`define CTRL_POWER_BIT 0
`define CTRL_GO_BIT 2
`define CTRL_CHAN_LSB 3
`define CTRL_CLK_LSB 6
`define CTRL_RESET 8'h00
`define PCFG_RESET 3'h0
`define CTRL_WMASK 8'hDD
// ==================================================
// Timing
`define TAD_HALVES_CONV 5'h13
`define TAD_HALVES_GAP 5'h04
`define DIV_2 6'h02
`define DIV_8 6'h08
`define DIV_32 6'h20
`define RC_TAD_NS 4000
`define CLK_PERIOD_NS 4
`endif

// ===== hdl/half_tad_gen.v
// Half bit-period tick generator from oscillator divide or internal RC time base
`timescale 1ns/1ps
`include "adc_seq_map.vh"
module half_tad_gen #(
  parameter RC_HALF_CYCLES = 500
) (
  sys_clk,
  reset_n,
  restart,
  clk_select,
  half_tick
);
  input wire sys_clk;
  input wire reset_n;
  input wire restart;
  input wire [1:0] clk_select;
  output reg half_tick;
  reg [15:0] count_reg;
  reg [15:0] limit;
  // ==================================================
  // Divide selection
  always @* begin
    case (clk_select)
      2'h0: limit = {10'h000, `DIV_2} >> 1;
      2'h1: limit = {10'h000, `DIV_8} >> 1;
      2'h2: limit = {10'h000, `DIV_32} >> 1;
      default: limit = RC_HALF_CYCLES[15:0];
    endcase
  end
  // ==================================================
  // Free-running counter, restarted at conversion start
  always @(posedge sys_clk) begin
    if (!reset_n || restart) begin
      count_reg <= 16'h0000;
      half_tick <= 1'b0;
    end else if (count_reg + 16'h0001 >= limit) begin
      count_reg <= 16'h0000;
      half_tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 16'h0001;
      half_tick <= 1'b0;
    end
  end
endmodule // half_tad_gen

// ===== hdl/adc_sequencer.v
// Converter control: registers over APB, pin configuration, conversion sequencing
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "adc_seq_map.vh"
module adc_sequencer #(
  parameter RC_HALF_CYCLES = `RC_TAD_NS / `CLK_PERIOD_NS / 2
) (
  sys_clk,
  reset_n,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  pin_level,
  sar_result,
  hold_connect,
  ref_external,
  mux_select,
  converter_power_on,
  irq
);
  input wire sys_clk;
  input wire reset_n;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  input wire [3:0] pin_level;
  input wire [7:0] sar_result;
  output reg hold_connect;
  output reg ref_external;
  output reg [1:0] mux_select;
  output reg converter_power_on;
  output reg irq;

  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_GAP = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] ctrl_reg;
  reg [2:0] pin_analog_select_reg;
  reg [7:0] conversion_result_reg;
  reg conversion_done_flag_reg;
  reg conversion_irq_enable_reg;
  reg [4:0] halves_reg;
  reg done_now;
  reg abort_now;
  reg restart_div;
  reg [3:0] analog_mask;
  reg [31:0] rd_data;
  reg addr_ok;
  wire half_tick;
  wire acc;
  wire wr;
  wire go_written;
  wire go_set;
  wire go_clear;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign go_written = wr && (paddr == `CTRL_ADDR);
  assign go_set = go_written && pwdata[`CTRL_GO_BIT] && !ctrl_reg[`CTRL_GO_BIT];
  assign go_clear = go_written && !pwdata[`CTRL_GO_BIT];

  half_tad_gen #(
    .RC_HALF_CYCLES(RC_HALF_CYCLES)
  ) u_tad (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .restart(restart_div),
    .clk_select(ctrl_reg[`CTRL_CLK_LSB+1:`CTRL_CLK_LSB]),
    .half_tick(half_tick)
  );

  // ==================================================
  // Pin configuration decode (bit order pin4, pin2, pin1, pin0)
  always @* begin
    case (pin_analog_select_reg)
      3'h0: analog_mask = 4'hF;
      3'h1: analog_mask = 4'hD;
      3'h2: analog_mask = 4'h7;
      3'h3: analog_mask = 4'h5;
      3'h4: analog_mask = 4'h3;
      3'h5: analog_mask = 4'h1;
      3'h6: analog_mask = 4'h1;
      default: analog_mask = 4'h0;
    endcase
  end

  // ==================================================
  // Conversion sequencer
  always @* begin
    state_next = state_reg;
    done_now = 1'b0;
    abort_now = 1'b0;
    restart_div = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // Power must already be on and stay on in the same write
        if (go_set && ctrl_reg[`CTRL_POWER_BIT] && pwdata[`CTRL_POWER_BIT]) begin
          state_next = ST_CONV;
          restart_div = 1'b1;
        end
      end
      ST_CONV: begin
        if (go_clear || !ctrl_reg[`CTRL_POWER_BIT]) begin
          abort_now = 1'b1;
          state_next = ST_GAP;
          restart_div = 1'b1;
        end else if (half_tick && halves_reg == `TAD_HALVES_CONV - 5'h01) begin
          done_now = 1'b1;
          state_next = ST_GAP;
        end
      end
      ST_GAP: begin
        if (half_tick && halves_reg == `TAD_HALVES_GAP - 5'h01) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      halves_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg || restart_div)
        halves_reg <= 5'h00;
      else if (half_tick)
        halves_reg <= halves_reg + 5'h01;
    end
  end

  // ==================================================
  // Registers
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_reg <= `CTRL_RESET;
      pin_analog_select_reg <= `PCFG_RESET;
      conversion_done_flag_reg <= 1'b0;
      conversion_irq_enable_reg <= 1'b0;
    end else begin
      if (wr && paddr == `CTRL_ADDR)
        ctrl_reg <= (pwdata[7:0] & `CTRL_WMASK) |
          ((state_reg == ST_IDLE && !ctrl_reg[`CTRL_POWER_BIT]) ? 8'h00 :
          (pwdata[7:0] & 8'h04));
      if (done_now)
        ctrl_reg[`CTRL_GO_BIT] <= 1'b0;
      else if (abort_now)
        ctrl_reg[`CTRL_GO_BIT] <= 1'b0;
      else if (go_set && (state_reg != ST_IDLE || !ctrl_reg[`CTRL_POWER_BIT] ||
          !pwdata[`CTRL_POWER_BIT]))
        ctrl_reg[`CTRL_GO_BIT] <= 1'b0;
      if (wr && paddr == `PCFG_ADDR)
        pin_analog_select_reg <= pwdata[2:0];
      if (wr && paddr == `MASK_ADDR)
        conversion_irq_enable_reg <= pwdata[0];
      // Set wins over write-one-to-clear
      if (done_now)
        conversion_done_flag_reg <= 1'b1;
      else if (wr && paddr == `STATUS_ADDR && pwdata[0])
        conversion_done_flag_reg <= 1'b0;
    end
  end

  // Result is not reset so its contents survive a device reset
  always @(posedge sys_clk) begin
    if (done_now)
      conversion_result_reg <= sar_result;
    else if (wr && paddr == `RESULT_ADDR && state_reg != ST_CONV)
      conversion_result_reg <= pwdata[7:0];
  end

  // ==================================================
  // APB read path, one wait-free access phase
  always @* begin
    addr_ok = 1'b1;
    rd_data = 32'h00000000;
    case (paddr)
      `CTRL_ADDR: rd_data = {24'h000000, ctrl_reg};
      `PCFG_ADDR: rd_data = {29'h00000000, pin_analog_select_reg};
      `RESULT_ADDR: rd_data = {24'h000000, conversion_result_reg};
      `STATUS_ADDR: rd_data = {31'h00000000, conversion_done_flag_reg};
      `MASK_ADDR: rd_data = {31'h00000000, conversion_irq_enable_reg};
      `PORT_ADDR: rd_data = {28'h0000000, pin_level & ~analog_mask};
      default: addr_ok = 1'b0;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      hold_connect <= 1'b0;
      ref_external <= 1'b0;
      mux_select <= 2'h0;
      converter_power_on <= 1'b0;
      irq <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= (psel && !penable && !pwrite) ? rd_data : 32'h00000000;
      // Sampling only while idle and powered; any pin converts regardless of direction
      hold_connect <= (state_next == ST_IDLE) && ctrl_reg[`CTRL_POWER_BIT];
      ref_external <= pin_analog_select_reg[0] && !(&pin_analog_select_reg);
      mux_select <= ctrl_reg[`CTRL_CHAN_LSB+1:`CTRL_CHAN_LSB];
      converter_power_on <= ctrl_reg[`CTRL_POWER_BIT];
      irq <= conversion_done_flag_reg && conversion_irq_enable_reg;
    end
  end
endmodule // adc_sequencer

// ===== sim/adc_pins_model.sv
// Far-side model: analog pins and converter core outcome
`timescale 1ns/1ps
module adc_pins_model (
  input wire hold_connect,
  input wire [1:0] mux_select,
  output logic [3:0] pin_level,
  output logic [7:0] sar_result
);
  // Pins sit high as inputs, so zero on a port read shows analog masking
  assign pin_level = 4'hF;
  // Outcome is only meaningful while the hold capacitor is isolated
  assign sar_result = hold_connect ? 8'h5A : {6'h28, mux_select};
endmodule // adc_pins_model

// ===== sim/adc_seq_assertions.sv
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
`include "adc_seq_map.vh"
module adc_seq_assertions (
  input wire sys_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire hold_connect,
  input wire ref_external,
  input wire [1:0] mux_select,
  input wire converter_power_on,
  input wire irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire wr = psel && penable && pwrite;
  // ====================
  // Properties
  property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("answer missing or too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  // Register lands at the access edge, the output copy one edge later
  property p_power;
    wr && paddr == `CTRL_ADDR |-> ##2 converter_power_on == $past(pwdata[0], 2);
  endproperty
  a_power: assert property (p_power) else $error("power bit not applied");
  property p_chan;
    wr && paddr == `CTRL_ADDR |-> ##2 mux_select == $past(pwdata[4:3], 2);
  endproperty
  a_chan: assert property (p_chan) else $error("channel not applied");
  property p_ref;
    wr && paddr == `PCFG_ADDR |-> ##2
      ref_external == ($past(pwdata[2:0], 2) inside {3'h1, 3'h3, 3'h5});
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");
  property p_rst; $rose(reset_n) |-> !converter_power_on && !irq && !hold_connect; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_off; !converter_power_on [*2] |-> !hold_connect; endproperty
  a_off: assert property (p_off) else $error("hold connected while off");
  // Shortest conversion plus gap is far above eight cycles
  property p_gap; $fell(hold_connect) && converter_power_on |=> !hold_connect [*8]; endproperty
  a_gap: assert property (p_gap) else $error("hold reconnected too soon");
  property p_mask; wr && paddr == `MASK_ADDR && !pwdata[0] |-> ##2 !irq; endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt still high");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_gap: cover property ($rose(hold_connect) && converter_power_on);
endmodule // adc_seq_assertions

bind adc_sequencer adc_seq_assertions i_adc_seq_assertions (.sys_clk, .reset_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .hold_connect, .ref_external,
  .mux_select, .converter_power_on, .irq);

// ===== sim/tb.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`include "adc_seq_map.vh"
module tb;
  logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic hold_connect, ref_external, converter_power_on, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [1:0] mux_select;
  logic [3:0] pin_level;
  logic [7:0] sar_result;
  // Reference pin is not an analog input, so it reads its level
  logic [3:0] port_exp [8] = '{4'h0, 4'h2, 4'h8, 4'hA, 4'hC, 4'hE, 4'hE, 4'hF};
  integer err_total = 0, checks_done = 0, i;
  // Short RC base keeps the slow clock option cheap to run
  adc_sequencer #(.RC_HALF_CYCLES(4)) i_adc_sequencer (.sys_clk, .reset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_level, .sar_result,
    .hold_connect, .ref_external, .mux_select, .converter_power_on, .irq);
  adc_pins_model i_adc_pins_model (.hold_connect, .mux_select, .pin_level, .sar_result);
  initial forever #2 sys_clk = ~sys_clk;
  // ====================
  // Tasks
  task end_sim;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done = checks_done + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Entered just after a rising edge; leaves one idle cycle so strobes never re-assert at once
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      n = n + 1;
      if (n > 20) begin
        err_total = err_total + 1;
        end_sim;
      end
      @(posedge sys_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task conv(input logic [1:0] s);
    logic [7:0] v;
    integer n;
    v = {s, 1'b0, s, 3'b001};
    wr(`CTRL_ADDR, {24'h0, v});
    // Go is refused during the settling gap, so wait for acquisition first
    n = 0;
    while (hold_connect !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n = n + 1;
    end
    if (n >= 400) begin
      err_total = err_total + 1;
      end_sim;
    end
    wr(`CTRL_ADDR, {24'h0, v | 8'h04});
    xfer(1'b0, `CTRL_ADDR, 32'h0);
    chk({31'h0, rd[2]}, 32'h1);
    n = 0;
    while (rd[2] === 1'b1 && n < 200) begin
      xfer(1'b0, `CTRL_ADDR, 32'h0);
      n = n + 1;
    end
    chk(rd, {24'h0, v});
    if (n >= 200) end_sim;
  endtask
  // ====================
  // Sequence
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total = err_total + 1;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1;
    @(posedge sys_clk);
    rdc(`CTRL_ADDR, 32'h0);
    rdc(`PCFG_ADDR, 32'h0);
    xfer(1'b0, 12'h0F0, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (i = 0; i < 8; i++) begin
      wr(`PCFG_ADDR, 32'(i));
      rdc(`PORT_ADDR, {28'h0, port_exp[i]});
    end
    wr(`MASK_ADDR, 32'h1);
    // All pins digital here, yet every channel must still convert
    for (i = 0; i < 4; i++) begin
      conv(i[1:0]);
      rdc(`RESULT_ADDR, 32'hA0 + 32'(i));
      rdc(`STATUS_ADDR, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(`STATUS_ADDR, 32'h1);
      rdc(`STATUS_ADDR, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    conv(2'h0);
    wr(`MASK_ADDR, 32'h0);
    rdc(`STATUS_ADDR, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`STATUS_ADDR, 32'h1);
    wr(`CTRL_ADDR, 32'h04);
    rdc(`CTRL_ADDR, 32'h0);
    wr(`CTRL_ADDR, 32'h81);
    wr(`CTRL_ADDR, 32'h85);
    wr(`CTRL_ADDR, 32'h81);
    rdc(`CTRL_ADDR, 32'h81);
    // Gap is two bit periods of sixteen-cycle halves, with margin
    repeat (80) @(posedge sys_clk);
    chk({31'h0, hold_connect}, 32'h1);
    rdc(`RESULT_ADDR, 32'hA0);
    rdc(`STATUS_ADDR, 32'h0);
    wr(`CTRL_ADDR, 32'h85);
    reset_n <= 0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1;
    @(posedge sys_clk);
    rdc(`CTRL_ADDR, 32'h0);
    rdc(`RESULT_ADDR, 32'hA0);
    end_sim;
  end
endmodule // tb
